// >>> src/prc_pkg.sv
package prc_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int PRC_NUM_PERIPH = 25;
    localparam int PRC_ADDR_W = 8;
    localparam int PRC_DATA_W = 32;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [PRC_ADDR_W-1:0] PRC_OFS_RESET_CTRL = 8'h00;
    localparam logic [PRC_ADDR_W-1:0] PRC_OFS_WD_MASK = 8'h04;
    localparam logic [PRC_ADDR_W-1:0] PRC_OFS_DONE_STAT = 8'h08;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [PRC_NUM_PERIPH-1:0] PRC_RST_RESET_CTRL = 25'h1FFFFFF;
    localparam logic [PRC_NUM_PERIPH-1:0] PRC_RST_WD_MASK = 25'h0000000;
    localparam logic [PRC_NUM_PERIPH-1:0] PRC_RST_DONE_STAT = 25'h0000000;
    localparam logic [PRC_DATA_W-1:0] PRC_RD_UNMAPPED = 32'h00000000;

    // ------------------------------------------------------------
    // Bit positions, identical in all three registers
    // ------------------------------------------------------------
    localparam int PRC_BIT_ADC = 0;
    localparam int PRC_BIT_BUS_CTRL = 1;
    localparam int PRC_BIT_DMA = 2;
    localparam int PRC_BIT_I2C_FIRST = 3;
    localparam int PRC_BIT_I2C_SECOND = 4;
    localparam int PRC_BIT_USER_IO_MUX = 5;
    localparam int PRC_BIT_FLASH_IO_MUX = 6;
    localparam int PRC_BIT_JTAG = 7;
    localparam int PRC_BIT_USER_PAD_CONTROL = 8;
    localparam int PRC_BIT_FLASH_PADS = 9;
    localparam int PRC_BIT_FIRST_PROGRAMMABLE_IO_BLOCK = 10;
    localparam int PRC_BIT_SECOND_PROGRAMMABLE_IO_BLOCK = 11;
    localparam int PRC_BIT_SYSTEM_PLL = 12;
    localparam int PRC_BIT_USB_PLL = 13;
    localparam int PRC_BIT_PWM = 14;
    localparam int PRC_BIT_RTC = 15;
    localparam int PRC_BIT_SPI_FIRST = 16;
    localparam int PRC_BIT_SPI_SECOND = 17;
    localparam int PRC_BIT_SYS_CONFIG = 18;
    localparam int PRC_BIT_CHIP_INFO = 19;
    localparam int PRC_BIT_TEST_MANAGER = 20;
    localparam int PRC_BIT_TIMER = 21;
    localparam int PRC_BIT_UART_FIRST = 22;
    localparam int PRC_BIT_UART_SECOND = 23;
    localparam int PRC_BIT_USB_CTRL = 24;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [PRC_ADDR_W-1:0] addr;
        logic [PRC_DATA_W-1:0] wrData;
        logic wr;
        logic rd;
    } prc_bus_req_t;

    typedef logic [PRC_NUM_PERIPH-1:0] prc_vec_t;

endpackage

// >>> src/prc_lane.sv
`timescale 1ns/1ps
`default_nettype none

module prc_lane (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic holdReset,
    input wire logic periphDoneIn,
    output logic periphResetOut,
    output logic doneStatus
);
    // ------------------------------------------------------------
    // Reset line
    // ------------------------------------------------------------
    // drive reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            periphResetOut <= 1'b1;
        end else begin
            periphResetOut <= holdReset;
        end
    end

    // ------------------------------------------------------------
    // Done tracking
    // ------------------------------------------------------------
    // Both the request and the driven line must be low, so a stale done
    // from before the reset edge can never leak through.
    // reflect peripheral done
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            doneStatus <= 1'b0;
        end else begin
            doneStatus <= !holdReset && !periphResetOut && periphDoneIn;
        end
    end

endmodule

`default_nettype wire

// >>> src/prc_bus_slave.sv
`timescale 1ns/1ps
`default_nettype none

module prc_bus_slave (
    input wire logic clk,
    input wire logic rst_n,
    input wire prc_pkg::prc_bus_req_t busReq,
    input wire prc_pkg::prc_vec_t ctrlVal,
    input wire prc_pkg::prc_vec_t maskVal,
    input wire prc_pkg::prc_vec_t doneVal,
    output logic wrCtrl,
    output logic wrMask,
    output logic [prc_pkg::PRC_DATA_W-1:0] rdData
);
    import prc_pkg::*;

    logic [PRC_DATA_W-1:0] rdData_d;

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    // Done status is read-only: a write to it is dropped silently.
    assign wrCtrl = busReq.wr && (busReq.addr == PRC_OFS_RESET_CTRL);
    assign wrMask = busReq.wr && (busReq.addr == PRC_OFS_WD_MASK);

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // readable done
    always_comb begin
        rdData_d = PRC_RD_UNMAPPED;
        case (busReq.addr)
            PRC_OFS_RESET_CTRL: rdData_d = {{(PRC_DATA_W-PRC_NUM_PERIPH){1'b0}}, ctrlVal};
            PRC_OFS_WD_MASK: rdData_d = {{(PRC_DATA_W-PRC_NUM_PERIPH){1'b0}}, maskVal};
            PRC_OFS_DONE_STAT: rdData_d = {{(PRC_DATA_W-PRC_NUM_PERIPH){1'b0}}, doneVal};
            default: rdData_d = PRC_RD_UNMAPPED;
        endcase
    end

    // Data is valid only in the cycle after the read strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdData <= PRC_RD_UNMAPPED;
        end else if (busReq.rd) begin
            rdData <= rdData_d;
        end else begin
            rdData <= PRC_RD_UNMAPPED;
        end
    end

endmodule

`default_nettype wire

// >>> src/prc_top.sv
// Functional notes
// - Reset-control bits come up set
// - Control bit one holds peripheral in reset
// - Watchdog fire resets mask-selected peripherals only
// - Read-only done bit per peripheral
// - Controller reset restores all register values
// - Serial and timing peripherals at fixed bits
// - System peripherals at fixed bit positions
// - Low bits fixed; bits 31-25 reserved
// - Watchdog mask resets to zero
// - Done bits read zero after reset
// - Done mirrors each peripheral's returned indication
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module prc_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [prc_pkg::PRC_ADDR_W-1:0] regAddr,
    input wire logic [prc_pkg::PRC_DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [prc_pkg::PRC_DATA_W-1:0] regRdData,
    input wire logic watchdogFire,
    input wire prc_pkg::prc_vec_t periphDoneIn,
    output prc_pkg::prc_vec_t periphResetOut
);
    import prc_pkg::*;

    prc_bus_req_t busReq;
    prc_vec_t resetCtrl_q;
    prc_vec_t resetCtrl_d;
    prc_vec_t wdMask_q;
    prc_vec_t doneStat;
    logic wrCtrl;
    logic wrMask;

    assign busReq = '{addr: regAddr, wrData: regWrData, wr: regWr, rd: regRd};

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    prc_bus_slave u_slave (
        .clk(clk),
        .rst_n(rst_n),
        .busReq(busReq),
        .ctrlVal(resetCtrl_q),
        .maskVal(wdMask_q),
        .doneVal(doneStat),
        .wrCtrl(wrCtrl),
        .wrMask(wrMask),
        .rdData(regRdData)
    );

    // ------------------------------------------------------------
    // Reset control register
    // ------------------------------------------------------------
    // A watchdog fire re-asserts the selected bits; it is ORed after the
    // software write so that a simultaneous clear cannot cancel it.
    // watchdog sets selected
    always_comb begin
        resetCtrl_d = resetCtrl_q;
        if (wrCtrl) begin
            resetCtrl_d = regWrData[PRC_NUM_PERIPH-1:0];
        end
        if (watchdogFire) begin
            resetCtrl_d = resetCtrl_d | wdMask_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            resetCtrl_q <= PRC_RST_RESET_CTRL;
        end else begin
            resetCtrl_q <= resetCtrl_d;
        end
    end

    // ------------------------------------------------------------
    // Watchdog select mask
    // ------------------------------------------------------------
    // mask resets clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wdMask_q <= PRC_RST_WD_MASK;
        end else if (wrMask) begin
            wdMask_q <= regWrData[PRC_NUM_PERIPH-1:0];
        end
    end

    // ------------------------------------------------------------
    // Per-peripheral reset and done
    // ------------------------------------------------------------
    // per-peripheral reset lines
    // done starts at zero
    // Lanes are wired by named bit, not by loop index, so a layout slip
    // shows up as a doubly driven bit instead of a silent swap.
    // serial and timing lanes
    prc_lane u_lane_usb_ctrl (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_USB_CTRL]),
        .periphDoneIn(periphDoneIn[PRC_BIT_USB_CTRL]),
        .periphResetOut(periphResetOut[PRC_BIT_USB_CTRL]),
        .doneStatus(doneStat[PRC_BIT_USB_CTRL])
    );
    prc_lane u_lane_uart_second (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_UART_SECOND]),
        .periphDoneIn(periphDoneIn[PRC_BIT_UART_SECOND]),
        .periphResetOut(periphResetOut[PRC_BIT_UART_SECOND]),
        .doneStatus(doneStat[PRC_BIT_UART_SECOND])
    );
    prc_lane u_lane_uart_first (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_UART_FIRST]),
        .periphDoneIn(periphDoneIn[PRC_BIT_UART_FIRST]),
        .periphResetOut(periphResetOut[PRC_BIT_UART_FIRST]),
        .doneStatus(doneStat[PRC_BIT_UART_FIRST])
    );
    prc_lane u_lane_timer (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_TIMER]),
        .periphDoneIn(periphDoneIn[PRC_BIT_TIMER]),
        .periphResetOut(periphResetOut[PRC_BIT_TIMER]),
        .doneStatus(doneStat[PRC_BIT_TIMER])
    );
    prc_lane u_lane_spi_second (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_SPI_SECOND]),
        .periphDoneIn(periphDoneIn[PRC_BIT_SPI_SECOND]),
        .periphResetOut(periphResetOut[PRC_BIT_SPI_SECOND]),
        .doneStatus(doneStat[PRC_BIT_SPI_SECOND])
    );
    prc_lane u_lane_spi_first (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_SPI_FIRST]),
        .periphDoneIn(periphDoneIn[PRC_BIT_SPI_FIRST]),
        .periphResetOut(periphResetOut[PRC_BIT_SPI_FIRST]),
        .doneStatus(doneStat[PRC_BIT_SPI_FIRST])
    );
    prc_lane u_lane_rtc (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_RTC]),
        .periphDoneIn(periphDoneIn[PRC_BIT_RTC]),
        .periphResetOut(periphResetOut[PRC_BIT_RTC]),
        .doneStatus(doneStat[PRC_BIT_RTC])
    );
    prc_lane u_lane_pwm (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_PWM]),
        .periphDoneIn(periphDoneIn[PRC_BIT_PWM]),
        .periphResetOut(periphResetOut[PRC_BIT_PWM]),
        .doneStatus(doneStat[PRC_BIT_PWM])
    );

    prc_lane u_lane_test_manager (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_TEST_MANAGER]),
        .periphDoneIn(periphDoneIn[PRC_BIT_TEST_MANAGER]),
        .periphResetOut(periphResetOut[PRC_BIT_TEST_MANAGER]),
        .doneStatus(doneStat[PRC_BIT_TEST_MANAGER])
    );
    prc_lane u_lane_chip_info (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_CHIP_INFO]),
        .periphDoneIn(periphDoneIn[PRC_BIT_CHIP_INFO]),
        .periphResetOut(periphResetOut[PRC_BIT_CHIP_INFO]),
        .doneStatus(doneStat[PRC_BIT_CHIP_INFO])
    );
    prc_lane u_lane_sys_config (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_SYS_CONFIG]),
        .periphDoneIn(periphDoneIn[PRC_BIT_SYS_CONFIG]),
        .periphResetOut(periphResetOut[PRC_BIT_SYS_CONFIG]),
        .doneStatus(doneStat[PRC_BIT_SYS_CONFIG])
    );
    prc_lane u_lane_usb_pll (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_USB_PLL]),
        .periphDoneIn(periphDoneIn[PRC_BIT_USB_PLL]),
        .periphResetOut(periphResetOut[PRC_BIT_USB_PLL]),
        .doneStatus(doneStat[PRC_BIT_USB_PLL])
    );
    prc_lane u_lane_system_pll (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_SYSTEM_PLL]),
        .periphDoneIn(periphDoneIn[PRC_BIT_SYSTEM_PLL]),
        .periphResetOut(periphResetOut[PRC_BIT_SYSTEM_PLL]),
        .doneStatus(doneStat[PRC_BIT_SYSTEM_PLL])
    );
    prc_lane u_lane_prog_io_second (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_SECOND_PROGRAMMABLE_IO_BLOCK]),
        .periphDoneIn(periphDoneIn[PRC_BIT_SECOND_PROGRAMMABLE_IO_BLOCK]),
        .periphResetOut(periphResetOut[PRC_BIT_SECOND_PROGRAMMABLE_IO_BLOCK]),
        .doneStatus(doneStat[PRC_BIT_SECOND_PROGRAMMABLE_IO_BLOCK])
    );
    prc_lane u_lane_prog_io_first (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_FIRST_PROGRAMMABLE_IO_BLOCK]),
        .periphDoneIn(periphDoneIn[PRC_BIT_FIRST_PROGRAMMABLE_IO_BLOCK]),
        .periphResetOut(periphResetOut[PRC_BIT_FIRST_PROGRAMMABLE_IO_BLOCK]),
        .doneStatus(doneStat[PRC_BIT_FIRST_PROGRAMMABLE_IO_BLOCK])
    );
    prc_lane u_lane_flash_pads (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_FLASH_PADS]),
        .periphDoneIn(periphDoneIn[PRC_BIT_FLASH_PADS]),
        .periphResetOut(periphResetOut[PRC_BIT_FLASH_PADS]),
        .doneStatus(doneStat[PRC_BIT_FLASH_PADS])
    );
    prc_lane u_lane_user_pads (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_USER_PAD_CONTROL]),
        .periphDoneIn(periphDoneIn[PRC_BIT_USER_PAD_CONTROL]),
        .periphResetOut(periphResetOut[PRC_BIT_USER_PAD_CONTROL]),
        .doneStatus(doneStat[PRC_BIT_USER_PAD_CONTROL])
    );

    prc_lane u_lane_jtag (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_JTAG]),
        .periphDoneIn(periphDoneIn[PRC_BIT_JTAG]),
        .periphResetOut(periphResetOut[PRC_BIT_JTAG]),
        .doneStatus(doneStat[PRC_BIT_JTAG])
    );
    prc_lane u_lane_flash_io_mux (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_FLASH_IO_MUX]),
        .periphDoneIn(periphDoneIn[PRC_BIT_FLASH_IO_MUX]),
        .periphResetOut(periphResetOut[PRC_BIT_FLASH_IO_MUX]),
        .doneStatus(doneStat[PRC_BIT_FLASH_IO_MUX])
    );
    prc_lane u_lane_user_io_mux (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_USER_IO_MUX]),
        .periphDoneIn(periphDoneIn[PRC_BIT_USER_IO_MUX]),
        .periphResetOut(periphResetOut[PRC_BIT_USER_IO_MUX]),
        .doneStatus(doneStat[PRC_BIT_USER_IO_MUX])
    );
    prc_lane u_lane_i2c_second (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_I2C_SECOND]),
        .periphDoneIn(periphDoneIn[PRC_BIT_I2C_SECOND]),
        .periphResetOut(periphResetOut[PRC_BIT_I2C_SECOND]),
        .doneStatus(doneStat[PRC_BIT_I2C_SECOND])
    );
    prc_lane u_lane_i2c_first (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_I2C_FIRST]),
        .periphDoneIn(periphDoneIn[PRC_BIT_I2C_FIRST]),
        .periphResetOut(periphResetOut[PRC_BIT_I2C_FIRST]),
        .doneStatus(doneStat[PRC_BIT_I2C_FIRST])
    );
    prc_lane u_lane_dma (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_DMA]),
        .periphDoneIn(periphDoneIn[PRC_BIT_DMA]),
        .periphResetOut(periphResetOut[PRC_BIT_DMA]),
        .doneStatus(doneStat[PRC_BIT_DMA])
    );
    prc_lane u_lane_bus_ctrl (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_BUS_CTRL]),
        .periphDoneIn(periphDoneIn[PRC_BIT_BUS_CTRL]),
        .periphResetOut(periphResetOut[PRC_BIT_BUS_CTRL]),
        .doneStatus(doneStat[PRC_BIT_BUS_CTRL])
    );
    prc_lane u_lane_adc (
        .clk(clk),
        .rst_n(rst_n),
        .holdReset(resetCtrl_q[PRC_BIT_ADC]),
        .periphDoneIn(periphDoneIn[PRC_BIT_ADC]),
        .periphResetOut(periphResetOut[PRC_BIT_ADC]),
        .doneStatus(doneStat[PRC_BIT_ADC])
    );

endmodule

`default_nettype wire

// >>> verif/prc_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module prc_top_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [prc_pkg::PRC_ADDR_W-1:0] regAddr,
    input wire logic [prc_pkg::PRC_DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [prc_pkg::PRC_DATA_W-1:0] regRdData,
    input wire logic watchdogFire,
    input wire prc_pkg::prc_vec_t periphDoneIn,
    input wire prc_pkg::prc_vec_t periphResetOut
);
    import prc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----
    // Port relations
    // ----
    a_rd_idle: assert property (!$past(regRd) |-> regRdData == 32'h0)
        else $error("read data not idle");
    a_reserved_zero: assert property (regRdData[31:25] == 7'h0)
        else $error("reserved bits not zero");
    a_boot_held: assert property ($rose(rst_n) |-> periphResetOut == 25'h1FFFFFF)
        else $error("resets not held after reset");
    a_wr_release: assert property (regWr && regAddr == 8'h00 && !watchdogFire ##1
        !regWr && !watchdogFire |=> periphResetOut == $past(regWrData[24:0], 2))
        else $error("reset output not following control write");
    a_no_release: assert property (!(regWr && regAddr == 8'h00) |-> ##2
        (~periphResetOut & $past(periphResetOut)) == 25'h0)
        else $error("reset released without a write");
    a_wd_mask: assert property (regWr && regAddr == 8'h04 ##1 watchdogFire && !regWr
        |-> ##2 periphResetOut == ($past(periphResetOut) | $past(regWrData[24:0], 3)))
        else $error("watchdog effect wrong");
    a_done_cause: assert property (regRd && regAddr == 8'h08 |=>
        (regRdData[24:0] & ($past(periphResetOut) | ~$past(periphDoneIn, 2))) == 25'h0)
        else $error("done set without its cause");
    a_unmapped_rd: assert property (regRd && !(regAddr inside {8'h00, 8'h04, 8'h08})
        |=> regRdData == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind prc_top prc_top_props p_u (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .watchdogFire(watchdogFire), .periphDoneIn(periphDoneIn), .periphResetOut(periphResetOut));
`default_nettype wire

// >>> verif/prc_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module prc_periph_model (
    input wire logic clk,
    input wire prc_pkg::prc_vec_t periphResetOut,
    input wire prc_pkg::prc_vec_t slowSel,
    output var prc_pkg::prc_vec_t periphDoneIn
);
    import prc_pkg::*;
    prc_vec_t stg1_q, stg2_q, stg3_q;
    // ----
    // Done return
    // ----
    // own done return
    always_ff @(posedge clk) begin
        stg1_q <= ~periphResetOut;
        stg2_q <= stg1_q & ~periphResetOut;
        stg3_q <= stg2_q & ~periphResetOut;
    end
    // Slow lanes make the poll loop actually wait
    assign periphDoneIn = ((stg1_q & ~slowSel) | (stg3_q & slowSel)) & ~periphResetOut;
endmodule
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import prc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic watchdogFire = 1'b0;
    logic [PRC_ADDR_W-1:0] regAddr = 8'h00;
    logic [PRC_DATA_W-1:0] regWrData = 32'h0;
    logic [PRC_DATA_W-1:0] regRdData, rdV;
    prc_vec_t periphDoneIn, periphResetOut;
    int badCount = 0;
    int nCompared = 0;
    initial forever #2 clk = ~clk;
    prc_top dut_u (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .watchdogFire(watchdogFire),
        .periphDoneIn(periphDoneIn), .periphResetOut(periphResetOut));
    prc_periph_model peer_u (.clk(clk), .periphResetOut(periphResetOut),
        .slowSel(25'h0AAAAAA), .periphDoneIn(periphDoneIn));
    // ----
    // Helpers
    // ----
    task automatic giveVerdict();
        $display("compared %0d mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            badCount++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkLines(input prc_vec_t got, input prc_vec_t exp);
        nCompared++;
        if (got !== exp) begin
            badCount++;
            $display("Error t=%0t lines got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 rdV = regRdData;
    endtask
    // Bounded poll of the done word, as software does before use
    task automatic waitDone(input logic [31:0] exp);
        for (int n = 0; n < 40 && rdV !== exp; n++) rd(8'h08);
        chk(rdV, exp);
        if (rdV !== exp) giveVerdict();
    endtask
    // ----
    // Scenarios
    // ----
    task automatic tResetVals();
        rd(8'h00); chk(rdV, 32'h01FFFFFF);
        rd(8'h04); chk(rdV, 32'h0);
        rd(8'h08); chk(rdV, 32'h0);
        chkLines(periphResetOut, 25'h1FFFFFF);
        wr(8'h08, 32'hFFFFFFFF);
        wr(8'h0C, 32'hFFFFFFFF);
        rd(8'h0C); chk(rdV, 32'h0);
        rd(8'h08); chk(rdV, 32'h0);
        $display("tResetVals done");
    endtask
    task automatic tLanes();
        for (int i = 0; i < 25; i++) begin
            wr(8'h00, ~(32'h1 << i));
            waitDone(32'h1 << i);
            chkLines(periphResetOut, 25'h1FFFFFF & ~(25'h1 << i));
            wr(8'h00, 32'hFFFFFFFF);
            rd(8'h08); chk(rdV, 32'h0);
        end
        $display("tLanes done");
    endtask
    task automatic tWatchdog();
        wr(8'h00, 32'hFE000000);
        waitDone(32'h01FFFFFF);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= 8'h04;
        regWrData <= 32'hFEC00001;
        @(posedge clk);
        regWr <= 1'b0;
        watchdogFire <= 1'b1;
        @(posedge clk);
        watchdogFire <= 1'b0;
        rd(8'h04); chk(rdV, 32'h00C00001);
        rd(8'h00); chk(rdV, 32'h00C00001);
        rd(8'h08); chk(rdV, 32'h013FFFFE);
        chkLines(periphResetOut, 25'h0C00001);
        // A fire in the same cycle as a clearing write must win
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= 8'h00;
        regWrData <= 32'h0;
        watchdogFire <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        watchdogFire <= 1'b0;
        rd(8'h00); chk(rdV, 32'h00C00001);
        $display("tWatchdog done");
    endtask
    task automatic tMidReset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h00); chk(rdV, 32'h01FFFFFF);
        rd(8'h04); chk(rdV, 32'h0);
        rd(8'h08); chk(rdV, 32'h0);
        chkLines(periphResetOut, 25'h1FFFFFF);
        $display("tMidReset done");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        tResetVals();
        tLanes();
        tWatchdog();
        tMidReset();
        giveVerdict();
    end
endmodule
`default_nettype wire
